// ### hsar_pkg.sv
// hsar_pkg: constants, types and register map of the hot swap alarm,
// fault timer and pin configuration register bank.
// assumes a byte-wide command-register port fed by the device's I2C engine.
package hsar_pkg;

    // command register offsets
    localparam logic [7:0] HSAR_ALERT_EN_OFS  = 8'h03;   // threshold alert enables
    localparam logic [7:0] HSAR_ALARM_LOG_OFS = 8'h05;   // adc_alarm_log
    localparam logic [7:0] HSAR_TB_TIME_OFS   = 8'h06;   // transistor_bad_timeout
    localparam logic [7:0] HSAR_PIN_CFG_OFS   = 8'h07;   // pin_configuration
    localparam logic [7:0] HSAR_THR_BASE_OFS  = 8'h08;   // first threshold (pin lower)
    localparam logic [7:0] HSAR_THR_LAST_OFS  = 8'h0F;   // last threshold (power upper)

    // reset values
    localparam logic [7:0] HSAR_LOG_RST       = 8'h00;
    localparam logic [7:0] HSAR_TB_TIME_RST   = 8'hFF;
    localparam logic [7:0] HSAR_PIN_CFG_RST   = 8'h00;
    localparam logic [7:0] HSAR_ALERT_EN_RST  = 8'h00;
    localparam logic [7:0] HSAR_LOWER_RST     = 8'h00;
    localparam logic [7:0] HSAR_UPPER_RST     = 8'hFF;
    localparam logic [7:0] HSAR_TB_DISABLED   = 8'h00;   // timeout code that turns check off

    // pin_configuration field positions
    localparam int HSAR_CFG_PIN3_PD   = 7;
    localparam int HSAR_CFG_PIN2_PD   = 6;
    localparam int HSAR_CFG_FUNC_HI   = 5;
    localparam int HSAR_CFG_FUNC_LO   = 4;
    localparam int HSAR_CFG_PIN1_OUT  = 3;
    localparam int HSAR_CFG_CONV_AL   = 2;
    localparam int HSAR_CFG_STRESS    = 1;
    localparam int HSAR_CFG_OVF_AL    = 0;

    // pin 1 function codes, field value {bit5, bit4}
    localparam logic [1:0] HSAR_FN_PWR_GOOD = 2'h0;
    localparam logic [1:0] HSAR_FN_GP_OUT   = 2'h1;
    localparam logic [1:0] HSAR_FN_PWR_BAD  = 2'h2;
    localparam logic [1:0] HSAR_FN_GP_IN    = 2'h3;

    // timing: one millisecond at 100 MHz
    localparam int HSAR_CLK_MHZ   = 100;
    localparam int HSAR_MS_US     = 1000;
    localparam int HSAR_MS_CYCLES = HSAR_MS_US * HSAR_CLK_MHZ;

    // measured quantities; code x2 is the alarm bit pair base
    typedef enum logic [1:0] {
        HSAR_CH_PIN,
        HSAR_CH_SRC,
        HSAR_CH_SENSE,
        HSAR_CH_POWER
    } hsar_chan_type;

    // one adc result
    typedef struct packed {
        logic          done;     // one-cycle conversion complete
        hsar_chan_type chan;     // which quantity
        logic [7:0]    value;    // upper 8 bits of the result
    } hsar_meas_type;

    // one command register access
    typedef struct packed {
        logic       wr;          // write strobe
        logic       rd;          // read strobe
        logic [7:0] addr;        // command register offset
        logic [7:0] wdata;       // write byte
    } hsar_cmd_type;

endpackage : hsar_pkg

// ### hsar_regs.sv
// hsar_regs: alarm log, transistor-bad timeout and pin configuration
// registers, with threshold compare, fault timer and pin drive.
// assumes command accesses arrive as one-cycle strobes from the I2C engine.
`timescale 1ns/10ps

module hsar_regs #(
    parameter int MS_CYCLES = hsar_pkg::HSAR_MS_CYCLES   // clock cycles per millisecond
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire hsar_pkg::hsar_cmd_type  cmd,
    output logic [7:0]                   rdata,
    input  wire hsar_pkg::hsar_meas_type meas,
    input  wire logic                    meter_overflow,
    input  wire logic                    transistor_bad_cond,
    input  wire logic                    stress_cond,
    input  wire logic                    power_good,
    output logic                         transistor_bad_fault,
    output logic                         alert_pulse,
    output logic                         pin1_o,
    output logic                         pin1_oe,
    output logic                         pin2_o,
    output logic                         pin2_oe,
    output logic                         pin3_o,
    output logic                         pin3_oe
);
    import hsar_pkg::*;

    localparam int CH_N = 4;                         // number of measured quantities
    localparam int MSW  = $clog2(MS_CYCLES + 1);     // millisecond divider width

    // threshold index of an offset, bit 0 selects upper
    function automatic logic [2:0] thr_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - HSAR_THR_BASE_OFS;
        return d[2:0];
    endfunction

    // true when offset lies in the threshold window
    function automatic logic is_thr(input logic [7:0] a);
        return (a >= HSAR_THR_BASE_OFS) && (a <= HSAR_THR_LAST_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]     alarm_log_r;                     // sticky alarm log
    logic [7:0]     alarm_log_nxt;                   // next log value
    logic [7:0]     tb_time_r;                       // transistor_bad_timeout
    logic [7:0]     pin_cfg_r;                       // pin_configuration
    logic [7:0]     alert_en_r;                      // per-threshold alert enables
    logic [7:0]     thr_lo_r [CH_N];                 // lower thresholds by channel
    logic [7:0]     thr_hi_r [CH_N];                 // upper thresholds by channel
    logic [7:0]     over_set;                        // log bits to set this cycle
    logic [7:0]     at_set;                          // at-or-beyond alert conditions
    logic [MSW-1:0] ms_cnt_r;                        // millisecond divider
    logic           ms_tick;                         // one-cycle per millisecond
    logic [7:0]     tb_ms_r;                         // elapsed ms of bad condition

    wire            wr_log = cmd.wr && (cmd.addr == HSAR_ALARM_LOG_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // threshold compare per channel
    generate
        for (genvar c = 0; c < CH_N; c++) begin : g_chan
            wire hit = meas.done && (meas.chan == hsar_chan_type'(c));
            // strictly beyond sets the log
            assign over_set[2*c+1] = hit && (meas.value > thr_hi_r[c]);
            assign over_set[2*c]   = hit && (meas.value < thr_lo_r[c]);
            // at or beyond feeds the alert
            assign at_set[2*c+1]   = hit && (meas.value >= thr_hi_r[c]);
            assign at_set[2*c]     = hit && (meas.value <= thr_lo_r[c]);

            // threshold storage, written through the command port
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    thr_lo_r[c] <= HSAR_LOWER_RST;
                    thr_hi_r[c] <= HSAR_UPPER_RST;
                end else if (cmd.wr && is_thr(cmd.addr)) begin
                    if (thr_index(cmd.addr) == 3'(2*c))
                        thr_lo_r[c] <= cmd.wdata;
                    if (thr_index(cmd.addr) == 3'(2*c+1))
                        thr_hi_r[c] <= cmd.wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // alarm log: set wins over a host write in the same cycle
    always_comb begin
        alarm_log_nxt = wr_log ? cmd.wdata : alarm_log_r;   // host writes 0 to clear
        alarm_log_nxt = alarm_log_nxt | over_set;
    end

    // log update
    always_ff @(posedge clk) begin
        if (!rst_n)
            alarm_log_r <= HSAR_LOG_RST;
        else
            alarm_log_r <= alarm_log_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tb_time_r  <= HSAR_TB_TIME_RST;
            pin_cfg_r  <= HSAR_PIN_CFG_RST;
            alert_en_r <= HSAR_ALERT_EN_RST;
        end else if (cmd.wr) begin
            if (cmd.addr == HSAR_TB_TIME_OFS)
                tb_time_r <= cmd.wdata;
            if (cmd.addr == HSAR_PIN_CFG_OFS)
                pin_cfg_r <= cmd.wdata;
            if (cmd.addr == HSAR_ALERT_EN_OFS)
                alert_en_r <= cmd.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (cmd.rd) begin
            if (cmd.addr == HSAR_ALARM_LOG_OFS)
                rdata <= alarm_log_r;
            else if (cmd.addr == HSAR_TB_TIME_OFS)
                rdata <= tb_time_r;
            else if (cmd.addr == HSAR_PIN_CFG_OFS)
                rdata <= pin_cfg_r;
            else if (cmd.addr == HSAR_ALERT_EN_OFS)
                rdata <= alert_en_r;
            else if (is_thr(cmd.addr))
                rdata <= thr_index(cmd.addr) % 2 == 0 ?
                         thr_lo_r[thr_index(cmd.addr) / 2] :
                         thr_hi_r[thr_index(cmd.addr) / 2];
            else
                rdata <= 8'h00;                              // unmapped reads zero
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick divider
    assign ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || !transistor_bad_cond || ms_tick)
            ms_cnt_r <= '0;                                  // restart with each episode
        else
            ms_cnt_r <= ms_cnt_r + MSW'(1);
    end

    // elapsed milliseconds of the bad condition
    always_ff @(posedge clk) begin
        if (!rst_n || !transistor_bad_cond)
            tb_ms_r <= 8'h00;
        else if (ms_tick && tb_ms_r != 8'hFF)
            tb_ms_r <= tb_ms_r + 8'h01;
    end

    // fault once the wait has elapsed, never when the wait is zero
    always_ff @(posedge clk) begin
        if (!rst_n)
            transistor_bad_fault <= 1'b0;
        else
            transistor_bad_fault <= transistor_bad_cond &&
                                    (tb_time_r != HSAR_TB_DISABLED) &&
                                    (tb_ms_r >= tb_time_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert pulse from enabled events
    always_ff @(posedge clk) begin
        if (!rst_n)
            alert_pulse <= 1'b0;
        else
            alert_pulse <= (|(at_set & alert_en_r)) ||
                           (meas.done && pin_cfg_r[HSAR_CFG_CONV_AL]) ||
                           (meter_overflow && pin_cfg_r[HSAR_CFG_OVF_AL]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive: all three pins are pull-low only
    logic [1:0] fn;                                          // pin 1 function
    assign fn = pin_cfg_r[HSAR_CFG_FUNC_HI:HSAR_CFG_FUNC_LO];

    // pin 1 enable by function
    always_ff @(posedge clk) begin
        if (!rst_n)
            pin1_oe <= 1'b0;
        else begin
            unique case (fn)
                HSAR_FN_PWR_GOOD: pin1_oe <= !power_good;    // released when good
                HSAR_FN_PWR_BAD:  pin1_oe <= power_good;     // released when bad
                HSAR_FN_GP_OUT:   pin1_oe <= !pin_cfg_r[HSAR_CFG_PIN1_OUT];
                HSAR_FN_GP_IN:    pin1_oe <= 1'b0;           // high impedance input
            endcase
        end
    end

    // pins 2 and 3
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin2_oe <= 1'b0;
            pin3_oe <= 1'b0;
        end else begin
            pin3_oe <= pin_cfg_r[HSAR_CFG_PIN3_PD];
            pin2_oe <= pin_cfg_r[HSAR_CFG_PIN2_PD] ||
                       (pin_cfg_r[HSAR_CFG_STRESS] && stress_cond);
        end
    end

    assign pin1_o = 1'b0;                                    // open drain: low only
    assign pin2_o = 1'b0;
    assign pin3_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_power_high_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_POWER && meas.value > thr_hi_r[3]
        |=> alarm_log_r[7]) else $error("power high not logged");

    chk_power_low_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_POWER && meas.value < thr_lo_r[3]
        |=> alarm_log_r[6]) else $error("power low not logged");

    chk_sense_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_SENSE && meas.value > thr_hi_r[2]
        |=> alarm_log_r[5]) else $error("sense high not logged");

    chk_src_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_SRC && meas.value < thr_lo_r[1]
        |=> alarm_log_r[2]) else $error("source low not logged");

    chk_sense_low_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_SENSE && meas.value < thr_lo_r[2]
        |=> alarm_log_r[4]) else $error("sense low not logged");

    chk_src_high_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_SRC && meas.value > thr_hi_r[1]
        |=> alarm_log_r[3]) else $error("source high not logged");

    chk_pin_high_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_PIN && meas.value > thr_hi_r[0]
        |=> alarm_log_r[1]) else $error("pin voltage high not logged");

    chk_pin_low_log: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_PIN && meas.value < thr_lo_r[0]
        |=> alarm_log_r[0]) else $error("pin voltage low not logged");

    chk_thr_alert: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && meas.chan == HSAR_CH_POWER && meas.value >= thr_hi_r[3] &&
        alert_en_r[7] |=> alert_pulse) else $error("threshold alert missing");

    chk_log_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        alarm_log_r[0] && !wr_log |=> alarm_log_r[0]) else $error("log bit lost");

    chk_tb_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        tb_time_r == HSAR_TB_DISABLED |=> !transistor_bad_fault)
        else $error("fault while timer disabled");

    chk_tb_needs_cond: assert property (@(posedge clk) disable iff (!rst_n)
        !transistor_bad_cond |=> !transistor_bad_fault) else $error("fault without cause");

    chk_pin3_pull: assert property (@(posedge clk) disable iff (!rst_n)
        pin_cfg_r[HSAR_CFG_PIN3_PD] |=> pin3_oe) else $error("pin 3 not pulled");

    chk_pin1_input: assert property (@(posedge clk) disable iff (!rst_n)
        fn == HSAR_FN_GP_IN |=> !pin1_oe) else $error("pin 1 driven as input");

    chk_conv_alert: assert property (@(posedge clk) disable iff (!rst_n)
        meas.done && pin_cfg_r[HSAR_CFG_CONV_AL] |=> alert_pulse)
        else $error("conversion alert missing");

    chk_stress_pin2: assert property (@(posedge clk) disable iff (!rst_n)
        stress_cond && pin_cfg_r[HSAR_CFG_STRESS] |=> pin2_oe)
        else $error("stress not shown on pin 2");

    chk_ovf_alert: assert property (@(posedge clk) disable iff (!rst_n)
        meter_overflow && pin_cfg_r[HSAR_CFG_OVF_AL] |=> alert_pulse)
        else $error("overflow alert missing");

    chk_quiet_alert: assert property (@(posedge clk) disable iff (!rst_n)
        !meas.done && !meter_overflow |=> !alert_pulse) else $error("alert without event");

    chk_thr_reset: assert property (@(posedge clk)
        !rst_n |=> thr_hi_r[0] == HSAR_UPPER_RST && thr_lo_r[0] == HSAR_LOWER_RST)
        else $error("threshold reset wrong");

endmodule : hsar_regs

// ### hsar_host_model.sv
// hsar_host_model: host side of the command-register port, standing in for
// the I2C engine that turns bus transfers into one-cycle byte strobes.
// assumes the bank samples strobes on the rising edge of clk.
`timescale 1ns/10ps

module hsar_host_model (
    input  wire logic                   clk,
    output hsar_pkg::hsar_cmd_type      cmd,
    input  wire logic [7:0]             rdata
);
    import hsar_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // idle port at time zero
    initial begin
        cmd = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    end

    ////////////////////////////////////////////////////////////////////////
    // one byte write: strobe for one cycle, then scramble address and data
    // so that a stale value can never be mistaken for a live one
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cmd <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // one byte read: rdata is registered at the strobe's sampling edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        #1 d = rdata;
    endtask
endmodule // hsar_host_model

// ### hsar_regs_tb_top.sv
// hsar_regs_tb_top: self-checking bench for the alarm log, fault timer and
// pin configuration bank; the ms prescaler is shortened to 10 cycles.
// assumes hsar_host_model drives the command port.
`timescale 1ns/10ps

module hsar_regs_tb_top;
    import hsar_pkg::*;

    localparam int MS = 10;                    // shortened millisecond

    logic           clk = 1'b0;                // 100 MHz clock
    logic           rst_n = 1'b0;              // synchronous reset
    hsar_cmd_type   cmd;                       // command strobes
    logic [7:0]     rdata;                     // read byte
    hsar_meas_type  meas = '0;                 // adc results
    logic           meter_overflow = 1'b0;     // overflow pulse
    logic           transistor_bad_cond = 1'b0;// raw fault condition
    logic           stress_cond = 1'b0;        // dissipation level
    logic           power_good = 1'b0;         // supply good level
    logic           transistor_bad_fault;      // timed fault
    logic           alert_pulse;               // alert strobe
    logic           pin1_o, pin2_o, pin3_o;    // pin data (always 0)
    logic           pin1_oe, pin2_oe, pin3_oe; // pin pull-low enables
    int             failures = 0;              // mismatch count
    int             num_checks = 0;            // comparison count

    always #5 clk = ~clk;

    hsar_regs #(.MS_CYCLES(MS)) u_hsar_regs (
        .clk(clk), .rst_n(rst_n), .cmd(cmd), .rdata(rdata), .meas(meas),
        .meter_overflow(meter_overflow), .transistor_bad_cond(transistor_bad_cond),
        .stress_cond(stress_cond), .power_good(power_good),
        .transistor_bad_fault(transistor_bad_fault), .alert_pulse(alert_pulse),
        .pin1_o(pin1_o), .pin1_oe(pin1_oe), .pin2_o(pin2_o), .pin2_oe(pin2_oe),
        .pin3_o(pin3_o), .pin3_oe(pin3_oe)
    );

    hsar_host_model u_hsar_host_model (.clk(clk), .cmd(cmd), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////
    // shared compare, verdict and stimulus helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t value mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one conversion result; al is the alert seen in the cycle after the take edge
    task automatic send_meas(input logic [1:0] ch, input logic [7:0] v, output logic al);
        @(posedge clk);
        meas <= '{done: 1'b1, chan: hsar_chan_type'(ch), value: v};
        @(posedge clk);
        meas <= '{done: 1'b0, chan: hsar_chan_type'(ch), value: ~v};
        #1 al = alert_pulse;
    endtask

    // one overflow pulse, alert sampled like send_meas
    task automatic send_ovf(output logic al);
        @(posedge clk);
        meter_overflow <= 1'b1;
        @(posedge clk);
        meter_overflow <= 1'b0;
        #1 al = alert_pulse;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset values, plus a write and read at an unmapped offset
    task automatic test_reset_values();
        logic [7:0] ofs [9] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0E, 8'h0F, 8'h20};
        logic [7:0] val [9] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
        logic [7:0] d;
        u_hsar_host_model.reg_write(8'h20, 8'h55);
        for (int i = 0; i < 9; i++) begin
            u_hsar_host_model.reg_read(ofs[i], d);
            chk(d, val[i]);
        end
    endtask

    // strict compares per channel, sticky bits, host clearing
    task automatic test_alarm_log();
        logic [7:0] d;
        logic [7:0] exp;
        logic       al;
        exp = 8'h00;
        for (int ch = 0; ch < 4; ch++) begin
            u_hsar_host_model.reg_write(HSAR_THR_BASE_OFS + 8'(2 * ch), 8'h40);
            u_hsar_host_model.reg_write(HSAR_THR_BASE_OFS + 8'(2 * ch + 1), 8'h80);
            send_meas(2'(ch), 8'h80, al);
            send_meas(2'(ch), 8'h40, al);
            u_hsar_host_model.reg_read(HSAR_ALARM_LOG_OFS, d);
            chk(d, exp);
            send_meas(2'(ch), 8'h81, al);
            chk({7'h00, al}, 8'h00);
            exp[2 * ch + 1] = 1'b1;
            send_meas(2'(ch), 8'h3F, al);
            exp[2 * ch] = 1'b1;
            u_hsar_host_model.reg_read(HSAR_ALARM_LOG_OFS, d);
            chk(d, exp);
        end
        send_meas(2'h3, 8'h60, al);
        u_hsar_host_model.reg_read(HSAR_ALARM_LOG_OFS, d);
        chk(d, 8'hFF);
        u_hsar_host_model.reg_write(HSAR_ALARM_LOG_OFS, 8'h0F);
        u_hsar_host_model.reg_read(HSAR_ALARM_LOG_OFS, d);
        chk(d, 8'h0F);
        u_hsar_host_model.reg_write(HSAR_ALARM_LOG_OFS, 8'h00);
        u_hsar_host_model.reg_read(HSAR_ALARM_LOG_OFS, d);
        chk(d, 8'h00);
    endtask

    // threshold, conversion and overflow alerts with their enables
    task automatic test_alerts();
        logic al;
        u_hsar_host_model.reg_write(HSAR_ALERT_EN_OFS, 8'h80);
        send_meas(2'h3, 8'h80, al);
        chk({7'h00, al}, 8'h01);
        send_meas(2'h2, 8'h80, al);
        chk({7'h00, al}, 8'h00);
        u_hsar_host_model.reg_write(HSAR_ALERT_EN_OFS, 8'h40);
        send_meas(2'h3, 8'h40, al);
        chk({7'h00, al}, 8'h01);
        u_hsar_host_model.reg_write(HSAR_PIN_CFG_OFS, 8'h04);
        send_meas(2'h0, 8'h60, al);
        chk({7'h00, al}, 8'h01);
        send_ovf(al);
        chk({7'h00, al}, 8'h00);
        u_hsar_host_model.reg_write(HSAR_PIN_CFG_OFS, 8'h01);
        send_meas(2'h0, 8'h60, al);
        chk({7'h00, al}, 8'h00);
        send_ovf(al);
        chk({7'h00, al}, 8'h01);
    endtask

    // pin drive table: {config, power_good, stress, pin3/pin2/pin1 enables}
    task automatic test_pins();
        logic [12:0] tbl [11] = '{
            {8'h80, 2'b10, 3'b100}, {8'h40, 2'b10, 3'b010}, {8'h00, 2'b00, 3'b001},
            {8'h00, 2'b10, 3'b000}, {8'h20, 2'b10, 3'b001}, {8'h20, 2'b00, 3'b000},
            {8'h10, 2'b10, 3'b001}, {8'h18, 2'b00, 3'b000}, {8'h30, 2'b00, 3'b000},
            {8'h02, 2'b11, 3'b010}, {8'h00, 2'b11, 3'b000}};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            power_good  <= tbl[i][4];
            stress_cond <= tbl[i][3];
            u_hsar_host_model.reg_write(HSAR_PIN_CFG_OFS, tbl[i][12:5]);
            repeat (3) @(posedge clk);
            #1 chk({5'h00, pin3_oe, pin2_oe, pin1_oe}, {5'h00, tbl[i][2:0]});
            chk({5'h00, pin3_o, pin2_o, pin1_o}, 8'h00);
        end
    endtask

    // millisecond fault timer and its disable code
    task automatic test_fault_timer();
        int cnt;
        u_hsar_host_model.reg_write(HSAR_TB_TIME_OFS, 8'h03);
        @(posedge clk);
        transistor_bad_cond <= 1'b1;
        cnt = 0;
        while (transistor_bad_fault !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            #1 cnt++;
        end
        chk(8'(cnt >= 3 * MS && cnt <= 3 * MS + 3), 8'h01);
        @(posedge clk);
        transistor_bad_cond <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, transistor_bad_fault}, 8'h00);
        u_hsar_host_model.reg_write(HSAR_TB_TIME_OFS, HSAR_TB_DISABLED);
        @(posedge clk);
        transistor_bad_cond <= 1'b1;
        cnt = 0;
        repeat (300) begin
            @(posedge clk);
            #1 cnt += int'(transistor_bad_fault === 1'b1);
        end
        chk(8'(cnt != 0), 8'h00);
        @(posedge clk);
        transistor_bad_cond <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        test_reset_values();
        test_alarm_log();
        test_alerts();
        test_pins();
        test_fault_timer();
        summarize();
    end

    // watchdog: all tests need a few thousand cycles at most
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule // hsar_regs_tb_top
